// ---- ctmw_mode_wake.sv ----
// Transceiver mode selection and standard bus wake-up detection.
// Assumes the serial host port decodes accesses into the write strobe and read buses here,
// and that the device mode machine lives outside and takes the Standby request.

`timescale 1ns/1ns

module ctmw_mode_wake
    import ctmw_pkg::*;
#(
    parameter int unsigned SILENCE_CYCLES = SILENCE_CYC,
    parameter int unsigned WAKE_TO_CYCLES = WAKE_TO_CYC
) (
    input  wire logic            CLK,
    input  wire logic            SRST,
    input  wire ctmw_dev_mode_e  DEV_MODE,
    input  wire logic            TXD_IN,
    input  wire logic            BUS_DOMINANT_IN,
    input  wire logic            TX_SUPPLY_UV_IN,
    input  wire logic            BAT_UV_IN,
    input  wire logic            BUS_WAKE_ENABLE,
    input  wire logic            CTRL_WR,
    input  wire logic [7:0]      CTRL_WDATA,
    input  wire logic            WAKE_EVENT_CLR,
    output      logic [7:0]      CTRL_RDATA,
    output      logic [7:0]      STATUS_RDATA,
    output      ctmw_xcvr_mode_e XCVR_MODE,
    output      logic            RXD_OUT,
    output      logic            BUS_TX_DOMINANT,
    output      logic            BIAS_MID,
    output      logic            BIAS_GND,
    output      logic            BUS_WAKE_EVENT,
    output      logic            REGULATOR_INHIBIT_OUT,
    output      logic            STANDBY_REQ
);

    ////////////////////////////////////////////////////////////////////////////////
    // Input synchronisers.

    logic [2:0] sync1_r;
    logic [2:0] sync2_r;
    logic       bus_dom;
    logic       tx_uv;
    logic       bat_uv;

    always_ff @(posedge CLK) begin
        if (SRST) begin
            sync1_r <= 3'h0;
            sync2_r <= 3'h0;
        end else begin
            sync1_r <= {BAT_UV_IN, TX_SUPPLY_UV_IN, BUS_DOMINANT_IN};
            sync2_r <= sync1_r;
        end
    end

    assign bus_dom = sync2_r[0];
    assign tx_uv   = sync2_r[1];
    assign bat_uv  = sync2_r[2];

    ////////////////////////////////////////////////////////////////////////////////
    // Control register.

    ctmw_ctrl_s ctrl_r;
    logic [1:0] sel;

    always_ff @(posedge CLK) begin
        if (SRST) begin
            ctrl_r <= ctmw_ctrl_s'(CTRL_RESET);
        end else if (CTRL_WR) begin
            ctrl_r <= ctmw_ctrl_s'(CTRL_WDATA & CTRL_WMASK);
        end
    end

    assign sel        = ctrl_r.transceiver_mode_select;
    assign CTRL_RDATA = ctrl_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Bus silence timer: counts since the last bus edge and saturates.

    logic             bus_dom_d_r;
    logic             bus_edge;
    logic [CNT_W-1:0] silence_cnt_r;
    logic             silent;

    assign bus_edge = bus_dom ^ bus_dom_d_r;
    assign silent   = (silence_cnt_r >= CNT_W'(SILENCE_CYCLES));

    always_ff @(posedge CLK) begin
        if (SRST) begin
            bus_dom_d_r   <= 1'b0;
            silence_cnt_r <= '0;
        end else begin
            bus_dom_d_r <= bus_dom;
            if (bus_edge) begin
                silence_cnt_r <= '0;
            end else if (!silent) begin
                silence_cnt_r <= silence_cnt_r + CNT_W'(1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Standard wake-up pattern detector.

    ctmw_wake_e       wk_r;
    logic [PH_W-1:0]  run_cnt_r;
    logic [CNT_W-1:0] wk_to_r;
    logic             wk_search;
    logic             run_dom_ok;
    logic             run_rec_ok;

    // Searching happens only in the offline modes and only for the plain pattern.
    assign wk_search = BUS_WAKE_ENABLE
                     && (XCVR_MODE == XM_OFFLINE || XCVR_MODE == XM_OFFLINE_BIAS)
                     && !(ctrl_r.selective_wake_enable && ctrl_r.selective_config_valid);

    // The run counter measures the current level; a level change restarts it, so a short
    // interval of either polarity simply never qualifies and leaves the phase untouched.
    assign run_dom_ok = bus_dom && !bus_edge && (run_cnt_r >= PH_W'(WAKE_DOM_CYC - 1));
    assign run_rec_ok = !bus_dom && !bus_edge && (run_cnt_r >= PH_W'(WAKE_REC_CYC - 1));

    always_ff @(posedge CLK) begin
        if (SRST || !wk_search) begin
            run_cnt_r <= '0;
        end else if (bus_edge) begin
            // The edge cycle already shows the new level, so it counts as the first one.
            run_cnt_r <= PH_W'(1);
        end else if (run_cnt_r != '1) begin
            run_cnt_r <= run_cnt_r + PH_W'(1);
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST || !wk_search) begin
            wk_r    <= WK_IDLE;
            wk_to_r <= '0;
        end else begin
            unique case (wk_r)
                WK_IDLE: begin
                    wk_to_r <= '0;
                    if (run_dom_ok) begin
                        wk_r <= WK_DOM1;
                    end
                end
                WK_DOM1: begin
                    wk_to_r <= wk_to_r + CNT_W'(1);
                    if (wk_to_r >= CNT_W'(WAKE_TO_CYCLES)) begin
                        wk_r <= WK_IDLE;
                    end else if (run_rec_ok) begin
                        wk_r <= WK_REC;
                    end
                end
                WK_REC: begin
                    wk_to_r <= wk_to_r + CNT_W'(1);
                    if (wk_to_r >= CNT_W'(WAKE_TO_CYCLES)) begin
                        wk_r <= WK_IDLE;
                    end else if (run_dom_ok) begin
                        wk_r <= WK_DOM2;
                    end
                end
                WK_DOM2: begin
                    wk_to_r <= '0;
                    wk_r    <= WK_IDLE;
                end
            endcase
        end
    end

    // WK_DOM2 is a one-cycle marker; the third phase is the same qualification as
    // the first dominant run, taken while the timeout has not run out.
    logic wake_pulse;

    assign wake_pulse = wk_search && (wk_r == WK_REC) && run_dom_ok
                        && (wk_to_r < CNT_W'(WAKE_TO_CYCLES));

    ////////////////////////////////////////////////////////////////////////////////
    // Sticky wake event flag; a new wake wins over a clear in the same cycle.

    logic wake_ev_r;

    always_ff @(posedge CLK) begin
        if (SRST) begin
            wake_ev_r <= 1'b0;
        end else if (wake_pulse) begin
            wake_ev_r <= 1'b1;
        end else if (WAKE_EVENT_CLR) begin
            wake_ev_r <= 1'b0;
        end
    end

    assign BUS_WAKE_EVENT = wake_ev_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Transceiver mode machine.

    ctmw_xcvr_mode_e mode_r;
    ctmw_xcvr_mode_e mode_nxt;
    ctmw_xcvr_mode_e leave_mode;

    // Dropping out of Active or Listen-only skips Offline Bias only on a silent bus.
    assign leave_mode = silent ? XM_OFFLINE : XM_OFFLINE_BIAS;

    always_comb begin
        mode_nxt = mode_r;
        if (DEV_MODE == DM_OFF || DEV_MODE == DM_OVERTEMP || bat_uv) begin
            mode_nxt = XM_OFF;
        end else if (mode_r == XM_OFF) begin
            mode_nxt = XM_OFFLINE;
        end else if (DEV_MODE == DM_NORMAL) begin
            unique case (mode_r)
                XM_ACTIVE: begin
                    if (sel == SEL_OFFLINE || (sel == SEL_ACT_UV && tx_uv)) begin
                        mode_nxt = leave_mode;
                    end else if (sel == SEL_LISTEN) begin
                        mode_nxt = XM_LISTEN;
                    end else begin
                        mode_nxt = XM_ACTIVE;
                    end
                end
                XM_LISTEN: begin
                    if (sel == SEL_OFFLINE) begin
                        mode_nxt = leave_mode;
                    end else if (sel == SEL_LISTEN || !TXD_IN) begin
                        mode_nxt = XM_LISTEN;
                    end else if (sel == SEL_ACT_UV && tx_uv) begin
                        mode_nxt = XM_LISTEN;
                    end else begin
                        mode_nxt = XM_ACTIVE;
                    end
                end
                default: begin
                    // Offline and Offline Bias under Normal mode.
                    if (sel == SEL_LISTEN) begin
                        mode_nxt = XM_LISTEN;
                    end else if (sel == SEL_ACT_NOUV || (sel == SEL_ACT_UV && !tx_uv)) begin
                        mode_nxt = TXD_IN ? XM_ACTIVE : XM_LISTEN;
                    end else if (sel == SEL_ACT_UV && tx_uv) begin
                        mode_nxt = XM_OFFLINE_BIAS;
                    end else if (mode_r == XM_OFFLINE && (bus_edge || wake_pulse)) begin
                        mode_nxt = XM_OFFLINE_BIAS;
                    end else if (mode_r == XM_OFFLINE_BIAS && silent) begin
                        mode_nxt = XM_OFFLINE;
                    end
                end
            endcase
        end else begin
            // Standby and Sleep ignore the select field entirely.
            unique case (mode_r)
                XM_ACTIVE, XM_LISTEN: mode_nxt = leave_mode;
                XM_OFFLINE: begin
                    if (bus_edge || wake_pulse) begin
                        mode_nxt = XM_OFFLINE_BIAS;
                    end
                end
                default: begin
                    if (silent) begin
                        mode_nxt = XM_OFFLINE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            mode_r <= XM_OFF;
        end else begin
            mode_r <= mode_nxt;
        end
    end

    assign XCVR_MODE = mode_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Pin outputs, all from flip-flops.

    always_ff @(posedge CLK) begin
        if (SRST) begin
            RXD_OUT         <= 1'b1;
            BUS_TX_DOMINANT <= 1'b0;
            BIAS_MID        <= 1'b0;
            BIAS_GND        <= 1'b0;
        end else begin
            BUS_TX_DOMINANT <= (mode_nxt == XM_ACTIVE) && !TXD_IN;
            BIAS_MID        <= (mode_nxt == XM_ACTIVE) || (mode_nxt == XM_LISTEN)
                               || (mode_nxt == XM_OFFLINE_BIAS);
            BIAS_GND        <= (mode_nxt == XM_OFFLINE);
            if (mode_nxt == XM_ACTIVE || mode_nxt == XM_LISTEN) begin
                RXD_OUT <= !bus_dom;
            end else if (DEV_MODE == DM_OFF) begin
                RXD_OUT <= 1'b1;
            end else begin
                // A pending wake keeps RXD low, even through Overtemp.
                RXD_OUT <= !(wake_ev_r || wake_pulse);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Regulator inhibit and Standby request.

    logic sleep_woken_r;

    always_ff @(posedge CLK) begin
        if (SRST || DEV_MODE != DM_SLEEP) begin
            sleep_woken_r <= 1'b0;
        end else if (wake_pulse) begin
            sleep_woken_r <= 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            REGULATOR_INHIBIT_OUT <= 1'b0;
            STANDBY_REQ           <= 1'b0;
        end else begin
            STANDBY_REQ           <= (DEV_MODE == DM_SLEEP) && wake_pulse;
            REGULATOR_INHIBIT_OUT <= (DEV_MODE == DM_STANDBY) || (DEV_MODE == DM_NORMAL)
                                     || (DEV_MODE == DM_OVERTEMP)
                                     || (DEV_MODE == DM_SLEEP && (wake_pulse || sleep_woken_r));
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Transceiver status register.

    ctmw_status_s status;

    always_comb begin
        status              = '0;
        status.xcvr_active  = (mode_r == XM_ACTIVE);
        status.bus_silent   = silent;
        status.tx_supply_uv = (sel == SEL_ACT_UV) && tx_uv;
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            STATUS_RDATA <= 8'h00;
        end else begin
            STATUS_RDATA <= status;
        end
    end

endmodule

// ---- ctmw_pkg.sv ----
// Constants, types and register layouts of the bus transceiver mode and wake block.
// Assumes one 25 MHz clock and a host port outside that decodes the serial register access.
//
// Operation
// - Normal mode with select 01 or 10 gives Active: TXD to bus, bus to RXD.
// - Select 01 watches transmitter supply; undervoltage drops Active to Offline or Offline Bias.
// - Select 10 ignores transmitter undervoltage; only forced Standby or Sleep drops to Offline modes.
// - Active requested with TXD low goes to Listen-only until TXD returns high.
// - Normal mode with select 11 gives Listen-only: transmitter off, receiver and bias on.
// - Listen-only holds while TXD low or select 01 with transmitter undervoltage.
// - Standby or Sleep forces Offline or Offline Bias, ignoring the select field.
// - Offline goes to Offline Bias on bus activity, back after the silence timeout.
// - Leaving Active or Listen-only goes to Offline if silent, else Offline Bias first.
// - Device entering Standby from Off or Overtemp puts the transceiver in Offline.
// - Offline goes to Offline Bias on wake pattern or select 01 with undervoltage.
// - Off, Overtemp or battery undervoltage switch it off; recovery re-enters Offline.
// - Offline with bus wake enabled watches for wake events, bus biased to ground.
// - Offline, wake enabled, selective wake off or invalid: search the standard pattern.
// - Wake pattern is dominant, recessive, dominant, each at least its minimum time.
// - Shorter intervals between phases are ignored and neither advance nor break the pattern.
// - Once the first dominant reaches its minimum, the rest must finish within the wake timeout, otherwise detection restarts.
// - RXD stays high until wake; a valid pattern sets the wake flag and drives RXD low.
// - Wake pattern in Sleep switches the inhibit output on and requests Standby.
// - A readable status bit shows whether the transceiver is ready or disabled.
// - That status bit is 1 in Active mode and 0 in every other mode.
// - Two-bit select: 00 Offline, 01 and 10 Active, 11 Listen-only.

package ctmw_pkg;

    localparam int unsigned CLK_MHZ       = 25;

    // Timing figures in their own units; cycle counts follow from the clock rate.
    localparam int unsigned T_SILENCE_US  = 1000;
    localparam int unsigned T_WAKE_TO_US  = 1000;
    localparam int unsigned T_WAKE_DOM_NS = 1000;
    localparam int unsigned T_WAKE_REC_NS = 1000;

    localparam int unsigned SILENCE_CYC   = T_SILENCE_US * CLK_MHZ;
    localparam int unsigned WAKE_TO_CYC   = T_WAKE_TO_US * CLK_MHZ;
    localparam int unsigned WAKE_DOM_CYC  = (T_WAKE_DOM_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned WAKE_REC_CYC  = (T_WAKE_REC_NS * CLK_MHZ + 999) / 1000;

    localparam int unsigned CNT_W         = 24;
    localparam int unsigned PH_W          = 12;

    localparam logic [1:0] SEL_OFFLINE    = 2'h0;
    localparam logic [1:0] SEL_ACT_UV     = 2'h1;
    localparam logic [1:0] SEL_ACT_NOUV   = 2'h2;
    localparam logic [1:0] SEL_LISTEN     = 2'h3;

    localparam logic [7:0] CTRL_RESET     = 8'h00;
    localparam logic [7:0] CTRL_WMASK     = 8'h73;

    typedef enum logic [2:0] {
        DM_OFF,
        DM_STANDBY,
        DM_NORMAL,
        DM_SLEEP,
        DM_OVERTEMP
    } ctmw_dev_mode_e;

    typedef enum logic [2:0] {
        XM_OFF,
        XM_OFFLINE,
        XM_OFFLINE_BIAS,
        XM_LISTEN,
        XM_ACTIVE
    } ctmw_xcvr_mode_e;

    typedef enum logic [1:0] {
        WK_IDLE,
        WK_DOM1,
        WK_REC,
        WK_DOM2
    } ctmw_wake_e;

    // Bus transceiver control register, 8 bits.
    typedef struct packed {
        logic       rsv7;
        logic       fd_tolerance_enable;
        logic       selective_config_valid;
        logic       selective_wake_enable;
        logic [1:0] rsv3_2;
        logic [1:0] transceiver_mode_select;
    } ctmw_ctrl_s;

    // Transceiver status register, 8 bits.
    typedef struct packed {
        logic       xcvr_active;
        logic [2:0] rsv6_4;
        logic       bus_silent;
        logic       rsv2;
        logic       tx_supply_uv;
        logic       rsv0;
    } ctmw_status_s;

endpackage

// ---- ctmw_ctrl_model.sv ----
// Protocol controller and bus wiring as seen from the transceiver pins.
// Assumes the bench sets the wanted transmit level and any foreign dominant drive.
`timescale 1ns/1ns

module ctmw_ctrl_model (
    input  wire logic tx_level,
    input  wire logic ext_dom,
    input  wire logic BUS_TX_DOMINANT,
    output      logic TXD_IN,
    output      logic BUS_DOMINANT_IN
);
    // The controller idles its transmit pin high; only the bench pulls it low.
    assign TXD_IN = tx_level;
    // The bus is wired-or of dominant drivers, so our own transmission loops back.
    assign BUS_DOMINANT_IN = BUS_TX_DOMINANT | ext_dom;
endmodule

// ---- ctmw_mode_wake_assertions.sv ----
// Port-level checks of the transceiver mode and wake block.
// Assumes one clock domain with synchronous reset SRST.
`timescale 1ns/1ns

module ctmw_mode_wake_checker
    import ctmw_pkg::*;
#(
    parameter int unsigned SILENCE_CYCLES = SILENCE_CYC,
    parameter int unsigned WAKE_TO_CYCLES = WAKE_TO_CYC
) (
    input wire logic            CLK,
    input wire logic            SRST,
    input wire ctmw_dev_mode_e  DEV_MODE,
    input wire logic            TXD_IN,
    input wire logic            CTRL_WR,
    input wire logic [7:0]      CTRL_WDATA,
    input wire logic            WAKE_EVENT_CLR,
    input wire logic [7:0]      CTRL_RDATA,
    input wire logic [7:0]      STATUS_RDATA,
    input wire ctmw_xcvr_mode_e XCVR_MODE,
    input wire logic            RXD_OUT,
    input wire logic            BUS_TX_DOMINANT,
    input wire logic            BIAS_MID,
    input wire logic            BIAS_GND,
    input wire logic            BUS_WAKE_EVENT,
    input wire logic            REGULATOR_INHIBIT_OUT,
    input wire logic            STANDBY_REQ
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);

    a_active_needs_normal: assert property (
        XCVR_MODE == XM_ACTIVE |-> $past(DEV_MODE) == DM_NORMAL)
        else $error("active outside normal");
    a_active_txd_high: assert property (
        $rose(XCVR_MODE == XM_ACTIVE) |-> $past(TXD_IN))
        else $error("active entered with txd low");
    a_tx_only_active: assert property (
        BUS_TX_DOMINANT |-> XCVR_MODE == XM_ACTIVE || $past(XCVR_MODE) == XM_ACTIVE)
        else $error("drive outside active");
    a_status_active: assert property (
        STATUS_RDATA[7] == ($past(XCVR_MODE) == XM_ACTIVE))
        else $error("status active bit wrong");
    a_ctrl_write: assert property (
        CTRL_WR |=> CTRL_RDATA == ($past(CTRL_WDATA) & CTRL_WMASK))
        else $error("control readback wrong");
    a_bias_exclusive: assert property (
        !(BIAS_MID && BIAS_GND))
        else $error("both biases on");
    a_off_floating: assert property (
        (XCVR_MODE == XM_OFF) [*2] |-> !BIAS_MID && !BIAS_GND)
        else $error("bias in off mode");
    a_wake_sticky: assert property (
        BUS_WAKE_EVENT && !WAKE_EVENT_CLR |=> BUS_WAKE_EVENT)
        else $error("wake flag lost");
    a_wake_rxd_low: assert property (
        $rose(BUS_WAKE_EVENT) && DEV_MODE != DM_OFF |-> !RXD_OUT)
        else $error("rxd not low on wake");
    a_standby_pulse: assert property (
        STANDBY_REQ |-> BUS_WAKE_EVENT ##1 !STANDBY_REQ)
        else $error("standby request wrong");
    a_inhibit_needs_wake: assert property (
        $rose(REGULATOR_INHIBIT_OUT) && DEV_MODE == DM_SLEEP |-> BUS_WAKE_EVENT)
        else $error("inhibit without wake");

    c_active: cover property ($rose(XCVR_MODE == XM_ACTIVE));
    c_listen: cover property (XCVR_MODE == XM_LISTEN);
    c_wake: cover property ($rose(BUS_WAKE_EVENT));
endmodule

bind ctmw_mode_wake ctmw_mode_wake_checker #(
    .SILENCE_CYCLES(SILENCE_CYCLES),
    .WAKE_TO_CYCLES(WAKE_TO_CYCLES)
) i_ctmw_mode_wake_checker (
    .CLK(CLK), .SRST(SRST), .DEV_MODE(DEV_MODE), .TXD_IN(TXD_IN), .CTRL_WR(CTRL_WR),
    .CTRL_WDATA(CTRL_WDATA), .WAKE_EVENT_CLR(WAKE_EVENT_CLR), .CTRL_RDATA(CTRL_RDATA),
    .STATUS_RDATA(STATUS_RDATA), .XCVR_MODE(XCVR_MODE), .RXD_OUT(RXD_OUT),
    .BUS_TX_DOMINANT(BUS_TX_DOMINANT), .BIAS_MID(BIAS_MID), .BIAS_GND(BIAS_GND),
    .BUS_WAKE_EVENT(BUS_WAKE_EVENT), .REGULATOR_INHIBIT_OUT(REGULATOR_INHIBIT_OUT),
    .STANDBY_REQ(STANDBY_REQ)
);

// ---- ctmw_mode_wake_tb.sv ----
// Self-checking bench of the transceiver mode and wake block.
// Assumes the bench plays the device mode machine and the host port decoder.
`timescale 1ns/1ns

module ctmw_mode_wake_tb;
    import ctmw_pkg::*;
    localparam int SIL = 200;
    logic            CLK, SRST, TX_SUPPLY_UV_IN, BAT_UV_IN, BUS_WAKE_ENABLE;
    logic            CTRL_WR, WAKE_EVENT_CLR, tx_level, ext_dom, TXD_IN, BUS_DOMINANT_IN;
    logic [7:0]      CTRL_WDATA, CTRL_RDATA, STATUS_RDATA;
    logic            RXD_OUT, BUS_TX_DOMINANT, BIAS_MID, BIAS_GND;
    logic            BUS_WAKE_EVENT, REGULATOR_INHIBIT_OUT, STANDBY_REQ;
    ctmw_dev_mode_e  DEV_MODE;
    ctmw_xcvr_mode_e XCVR_MODE;
    int              num_errors = 0;
    int              samples_checked = 0;

    ctmw_mode_wake #(.SILENCE_CYCLES(SIL), .WAKE_TO_CYCLES(300)) i_ctmw_mode_wake (
        .CLK(CLK), .SRST(SRST), .DEV_MODE(DEV_MODE), .TXD_IN(TXD_IN),
        .BUS_DOMINANT_IN(BUS_DOMINANT_IN), .TX_SUPPLY_UV_IN(TX_SUPPLY_UV_IN),
        .BAT_UV_IN(BAT_UV_IN), .BUS_WAKE_ENABLE(BUS_WAKE_ENABLE), .CTRL_WR(CTRL_WR),
        .CTRL_WDATA(CTRL_WDATA), .WAKE_EVENT_CLR(WAKE_EVENT_CLR), .CTRL_RDATA(CTRL_RDATA),
        .STATUS_RDATA(STATUS_RDATA), .XCVR_MODE(XCVR_MODE), .RXD_OUT(RXD_OUT),
        .BUS_TX_DOMINANT(BUS_TX_DOMINANT), .BIAS_MID(BIAS_MID), .BIAS_GND(BIAS_GND),
        .BUS_WAKE_EVENT(BUS_WAKE_EVENT), .REGULATOR_INHIBIT_OUT(REGULATOR_INHIBIT_OUT),
        .STANDBY_REQ(STANDBY_REQ));

    ctmw_ctrl_model i_ctmw_ctrl_model (.tx_level(tx_level), .ext_dom(ext_dom),
        .BUS_TX_DOMINANT(BUS_TX_DOMINANT), .TXD_IN(TXD_IN), .BUS_DOMINANT_IN(BUS_DOMINANT_IN));

    initial begin
        CLK = 1'b0;
        forever #20 CLK = ~CLK;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic step(input int n);
        repeat (n) @(posedge CLK);
        #2;
    endtask

    task automatic test_done;
        $display("checked %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Waits stay bounded so a stuck mode ends the run instead of hanging it.
    task automatic chk_mode(input ctmw_xcvr_mode_e exp, input int bound);
        for (int i = 0; i < bound && XCVR_MODE !== exp; i++) step(1);
        chk({5'h00, XCVR_MODE}, {5'h00, exp});
        if (XCVR_MODE !== exp) test_done();
    endtask

    task automatic wr(input logic [7:0] d);
        CTRL_WR = 1'b1;
        CTRL_WDATA = d;
        step(1);
        CTRL_WR = 1'b0;
        step(1);
    endtask

    task automatic drive(input logic dom, input int n);
        ext_dom = dom;
        step(n);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        chk_mode(XM_OFFLINE, 4);
        chk(CTRL_RDATA, 8'h00);
        chk({7'h00, RXD_OUT}, 8'h01);
        wr(8'hff);
        chk(CTRL_RDATA, 8'h73);
        wr(8'h00);
        $display("reset test done");
    endtask

    task automatic t_select;
        ctmw_xcvr_mode_e exp [4] = '{XM_ACTIVE, XM_ACTIVE, XM_LISTEN, XM_OFFLINE};
        step(SIL + 10);
        DEV_MODE = DM_NORMAL;
        for (int i = 0; i < 4; i++) begin
            wr(8'((i + 1) % 4));
            chk_mode(exp[i], 8);
            step(2);
            // The bus has stayed recessive since reset, so the silence bit stands too.
            chk(STATUS_RDATA, {exp[i] == XM_ACTIVE, 7'h08});
        end
        $display("select test done");
    endtask

    task automatic t_txd;
        tx_level = 1'b0;
        wr(8'h01);
        chk_mode(XM_LISTEN, 8);
        step(20);
        chk_mode(XM_LISTEN, 1);
        tx_level = 1'b1;
        chk_mode(XM_ACTIVE, 8);
        tx_level = 1'b0;
        step(6);
        chk({6'h00, BUS_TX_DOMINANT, RXD_OUT}, 8'h02);
        tx_level = 1'b1;
        step(6);
        chk({6'h00, BUS_TX_DOMINANT, RXD_OUT}, 8'h01);
        $display("txd test done");
    endtask

    task automatic t_uv;
        TX_SUPPLY_UV_IN = 1'b1;
        chk_mode(XM_OFFLINE_BIAS, 10);
        step(2);
        chk({7'h00, STATUS_RDATA[1]}, 8'h01);
        wr(8'h02);
        chk_mode(XM_ACTIVE, 10);
        step(2);
        chk({7'h00, STATUS_RDATA[1]}, 8'h00);
        TX_SUPPLY_UV_IN = 1'b0;
        $display("uv test done");
    endtask

    task automatic t_standby;
        DEV_MODE = DM_STANDBY;
        chk_mode(XM_OFFLINE_BIAS, 8);
        chk_mode(XM_OFFLINE, SIL + 20);
        drive(1'b1, 3);
        drive(1'b0, 1);
        chk_mode(XM_OFFLINE_BIAS, 8);
        chk({6'h00, BIAS_MID, BIAS_GND}, 8'h02);
        chk_mode(XM_OFFLINE, SIL + 20);
        chk({6'h00, BIAS_MID, BIAS_GND}, 8'h01);
        $display("standby test done");
    endtask

    task automatic t_wake;
        int i;
        DEV_MODE = DM_SLEEP;
        BUS_WAKE_ENABLE = 1'b1;
        step(4);
        chk({7'h00, REGULATOR_INHIBIT_OUT}, 8'h00);
        drive(1'b1, 30);
        drive(1'b0, 15);
        chk({7'h00, RXD_OUT}, 8'h01);
        drive(1'b1, 5);
        drive(1'b0, 30);
        ext_dom = 1'b1;
        for (i = 0; i < 40 && STANDBY_REQ !== 1'b1; i++) step(1);
        chk({7'h00, STANDBY_REQ}, 8'h01);
        if (STANDBY_REQ !== 1'b1) test_done();
        step(1);
        chk({5'h00, BUS_WAKE_EVENT, RXD_OUT, REGULATOR_INHIBIT_OUT}, 8'h05);
        drive(1'b0, 1);
        DEV_MODE = DM_STANDBY;
        WAKE_EVENT_CLR = 1'b1;
        step(1);
        WAKE_EVENT_CLR = 1'b0;
        step(4);
        chk({6'h00, BUS_WAKE_EVENT, RXD_OUT}, 8'h01);
        $display("wake test done");
    endtask

    task automatic t_wake_timeout;
        DEV_MODE = DM_SLEEP;
        // A valid selective setup hands waking to the frame filter, so the plain pattern is dead.
        wr(8'h32);
        drive(1'b1, 30);
        drive(1'b0, 30);
        drive(1'b1, 30);
        drive(1'b0, 5);
        chk({6'h00, BUS_WAKE_EVENT, STANDBY_REQ}, 8'h00);
        wr(8'h02);
        drive(1'b1, 30);
        drive(1'b0, 400);
        drive(1'b1, 30);
        drive(1'b0, 5);
        chk({6'h00, BUS_WAKE_EVENT, STANDBY_REQ}, 8'h00);
        $display("wake timeout test done");
    endtask

    task automatic t_off;
        DEV_MODE = DM_OFF;
        chk_mode(XM_OFF, 8);
        chk({6'h00, BIAS_MID, BIAS_GND}, 8'h00);
        DEV_MODE = DM_STANDBY;
        chk_mode(XM_OFFLINE, 8);
        BAT_UV_IN = 1'b1;
        chk_mode(XM_OFF, 8);
        BAT_UV_IN = 1'b0;
        chk_mode(XM_OFFLINE, 8);
        $display("off test done");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        SRST = 1'b1;
        DEV_MODE = DM_STANDBY;
        tx_level = 1'b1;
        ext_dom = 1'b0;
        TX_SUPPLY_UV_IN = 1'b0;
        BAT_UV_IN = 1'b0;
        BUS_WAKE_ENABLE = 1'b0;
        CTRL_WR = 1'b0;
        CTRL_WDATA = 8'h00;
        WAKE_EVENT_CLR = 1'b0;
        step(16);
        SRST = 1'b0;
        t_reset();
        t_select();
        t_txd();
        t_uv();
        t_standby();
        t_wake();
        t_wake_timeout();
        t_off();
        test_done();
    end
endmodule
